// ==== core/event_consts.svh ====
// Purpose: offsets, fields, reset values and times of the event recorder
// Assumes: byte addresses on a 32-bit APB bus
// Notes:   times in their own unit, cycle counts derived in the module
`ifndef EVENT_CONSTS_SVH
`define EVENT_CONSTS_SVH
`define CLK_PERIOD_NS   10
`define MS_NS           1000000
`define FILT_MIN_MS     10
`define FILT_MAX_MS     100
`define BLINK_MS        500
`define LINK_TIMEOUT_MS 100
`define FAULT_HOLD_MS   50
`define ADDR_CTRL       12'h000
`define ADDR_STATUS     12'h004
`define ADDR_MASK       12'h008
`define ADDR_REC_INFO   12'h00c
`define ADDR_REC_TIME   12'h010
`define ADDR_LEVELS     12'h014
`define ADDR_TIME       12'h018
`define ADDR_FILT_BASE  12'h040
`define ADDR_FILT_LAST  12'h0bc
`define CTRL_LOADED     0
`define STS_EVENT       0
`define STS_FAULT       1
`define REC_LVL         8
`define REC_VALID       31
`define FILT_RESET      7'h0a
`endif

// ==== core/event_pkg.sv ====
// Purpose: shared types of the event recorder
// Assumes: nothing beyond the constants header
// Notes:   none
package event_pkg;
  typedef logic [4:0] chan_t;
  typedef logic [6:0] filt_t;
  typedef enum logic {HEALTH_RUN, HEALTH_FAULT} health_e;
endpackage

// ==== core/input_event_timestamp_module.sv ====
// Purpose: 32-point debounced input recorder with millisecond time stamps
// Assumes: APB slave, one clock, controller drains records by W1C
// Notes:   one record held at a time; further changes wait in the filter
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "event_consts.svh"

// Summary of operation
// - 32 inputs in two groups of 16
// - per-point filter time 10 to 100 ms
// - each accepted change recorded with ms time
// - controller loads parameters, device applies them
// - self-check fault restarts the device
// - run lamp blinks when loaded, steady otherwise
// - link lamp lit while controller talks
// - fault lamp lit during a fault
// - channel lamps show filtered levels
module input_event_timestamp_module
  import event_pkg::*;
#(
  parameter int TICK_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] din_grp0,
  input  wire logic [15:0] din_grp1,
  output logic             irq,
  output logic             run_led,
  output logic             link_led,
  output logic             fault_led,
  output logic      [31:0] level_led
);
  // a one-cycle tick leaves the tick counter nothing to count
  if (TICK_CYCLES < 2) begin
    $error("tick too short");
  end

  // input synchronisers
  logic [31:0] s1_r, s2_r, s3_r, raw_r, raw_nxt;
  always_comb begin
    raw_nxt = (s2_r & ~(s2_r ^ s3_r)) | (raw_r & (s2_r ^ s3_r));
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r  <= 32'h0;
      s2_r  <= 32'h0;
      s3_r  <= 32'h0;
      raw_r <= 32'h0;
    end else begin
      s1_r  <= {din_grp1, din_grp0};
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      raw_r <= raw_nxt;
    end
  end

  // timebase, self-check, health
  logic [31:0] tick_r, tick_nxt, ms_r, ms_nxt, chk_r, chk_nxt;
  logic [9:0]  hold_r, hold_nxt;
  health_e     health_r, health_nxt;
  logic        tick, mismatch, soft_rst;
  assign tick     = (tick_r == 32'(TICK_CYCLES - 1));
  assign mismatch = (ms_r != chk_r);
  always_comb begin
    tick_nxt   = tick ? 32'h0 : tick_r + 32'h1;
    ms_nxt     = tick ? ms_r + 32'h1 : ms_r;
    chk_nxt    = tick ? chk_r + 32'h1 : chk_r;
    hold_nxt   = hold_r;
    health_nxt = health_r;
    soft_rst   = 1'b0;
    case (health_r)
      HEALTH_RUN: begin
        if (mismatch) begin
          health_nxt = HEALTH_FAULT;
          hold_nxt   = 10'h0;
          soft_rst   = 1'b1;
        end
      end
      HEALTH_FAULT: begin
        ms_nxt  = 32'h0;
        chk_nxt = 32'h0;
        if (tick) hold_nxt = hold_r + 10'h1;
        if (hold_r == 10'(`FAULT_HOLD_MS)) health_nxt = HEALTH_RUN;
      end
      default: health_nxt = HEALTH_RUN;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r   <= 32'h0;
      ms_r     <= 32'h0;
      chk_r    <= 32'h0;
      hold_r   <= 10'h0;
      health_r <= HEALTH_RUN;
    end else begin
      tick_r   <= tick_nxt;
      ms_r     <= ms_nxt;
      chk_r    <= chk_nxt;
      hold_r   <= hold_nxt;
      health_r <= health_nxt;
    end
  end

  // APB slave and registers
  filt_t       filt_r [32];
  filt_t       filt_nxt [32];
  logic [31:0] prdata_nxt;
  logic [1:0]  sts_r, sts_nxt, mask_r, mask_nxt;
  logic        pready_nxt, pslverr_nxt, loaded_r, loaded_nxt, acc, wr, bad;
  logic        commit;
  chan_t       gnt;
  logic [31:0] flt_r;
  logic        rec_v_r, rec_l_r;
  chan_t       rec_ch_r;
  logic [31:0] rec_t_r;
  logic        in_filt, filt_ok;
  logic [4:0]  fidx;
  assign acc     = psel && penable && pready;
  assign wr      = acc && pwrite;
  assign in_filt = paddr >= `ADDR_FILT_BASE && paddr <= `ADDR_FILT_LAST && paddr[1:0] == 2'h0;
  assign fidx    = 5'((paddr - `ADDR_FILT_BASE) >> 2);
  assign filt_ok = pwdata >= 32'(`FILT_MIN_MS) && pwdata <= 32'(`FILT_MAX_MS);
  always_comb begin
    bad = !(in_filt || paddr == `ADDR_CTRL || paddr == `ADDR_STATUS || paddr == `ADDR_MASK
            || paddr == `ADDR_REC_INFO || paddr == `ADDR_REC_TIME || paddr == `ADDR_LEVELS
            || paddr == `ADDR_TIME);
    if (pwrite && in_filt && !filt_ok) bad = 1'b1;
    prdata_nxt = 32'h0;
    case (paddr)
      `ADDR_CTRL:     prdata_nxt[`CTRL_LOADED] = loaded_r;
      `ADDR_STATUS:   prdata_nxt = {30'h0, sts_r};
      `ADDR_MASK:     prdata_nxt = {30'h0, mask_r};
      `ADDR_REC_INFO: prdata_nxt = {rec_v_r, 22'h0, rec_l_r, 3'h0, rec_ch_r};
      `ADDR_REC_TIME: prdata_nxt = rec_t_r;
      `ADDR_LEVELS:   prdata_nxt = flt_r;
      `ADDR_TIME:     prdata_nxt = ms_r;
      default:        if (in_filt) prdata_nxt = {25'h0, filt_r[fidx]};
    endcase
    pready_nxt  = psel && penable && !pready;
    pslverr_nxt = pready_nxt && bad;
    if (!pready_nxt) prdata_nxt = 32'h0;
    filt_nxt   = filt_r;
    loaded_nxt = loaded_r;
    mask_nxt   = mask_r;
    sts_nxt    = sts_r;
    if (wr && !pslverr) begin
      if (in_filt) filt_nxt[fidx] = filt_t'(pwdata[6:0]);
      if (paddr == `ADDR_CTRL) loaded_nxt = pwdata[`CTRL_LOADED];
      if (paddr == `ADDR_MASK) mask_nxt = pwdata[1:0];
      if (paddr == `ADDR_STATUS) sts_nxt = sts_r & ~pwdata[1:0];
    end
    // hardware set wins over a same-cycle clear
    if (commit) sts_nxt[`STS_EVENT] = 1'b1;
    if (soft_rst) begin
      sts_nxt[`STS_FAULT] = 1'b1;
      loaded_nxt = 1'b0;
      for (int i = 0; i < 32; i++) filt_nxt[i] = `FILT_RESET;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata   <= 32'h0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      loaded_r <= 1'b0;
      mask_r   <= 2'h0;
      sts_r    <= 2'h0;
      for (int i = 0; i < 32; i++) filt_r[i] <= `FILT_RESET;
    end else begin
      prdata   <= prdata_nxt;
      pready   <= pready_nxt;
      pslverr  <= pslverr_nxt;
      loaded_r <= loaded_nxt;
      mask_r   <= mask_nxt;
      sts_r    <= sts_nxt;
      filt_r   <= filt_nxt;
    end
  end

  // debounce and event record
  filt_t       cnt_r [32];
  filt_t       cnt_nxt [32];
  logic [31:0] flt_nxt, ripe;
  logic        rec_v_nxt, rec_l_nxt;
  chan_t       rec_ch_nxt;
  logic [31:0] rec_t_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    ripe    = 32'h0;
    for (int i = 0; i < 32; i++) begin
      if (raw_r[i] == flt_r[i]) cnt_nxt[i] = 7'h0;
      else if (tick && cnt_r[i] != 7'h7f) cnt_nxt[i] = cnt_r[i] + 7'h1;
      ripe[i] = raw_r[i] != flt_r[i] && cnt_r[i] >= filt_r[i];
    end
    gnt = 5'h0;
    for (int i = 31; i >= 0; i--) if (ripe[i]) gnt = 5'(i);
    // a full record holds back later changes rather than dropping them
    commit     = |ripe && !rec_v_r && health_r == HEALTH_RUN;
    flt_nxt    = flt_r;
    rec_v_nxt  = rec_v_r;
    rec_l_nxt  = rec_l_r;
    rec_ch_nxt = rec_ch_r;
    rec_t_nxt  = rec_t_r;
    if (wr && !pslverr && paddr == `ADDR_STATUS && pwdata[`STS_EVENT]) rec_v_nxt = 1'b0;
    if (commit) begin
      flt_nxt[gnt] = raw_r[gnt];
      cnt_nxt[gnt] = 7'h0;
      rec_v_nxt    = 1'b1;
      rec_l_nxt    = raw_r[gnt];
      rec_ch_nxt   = gnt;
      rec_t_nxt    = ms_r;
    end
    if (soft_rst) begin
      rec_v_nxt = 1'b0;
      for (int i = 0; i < 32; i++) cnt_nxt[i] = 7'h0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_r    <= 32'h0;
      rec_v_r  <= 1'b0;
      rec_l_r  <= 1'b0;
      rec_ch_r <= 5'h0;
      rec_t_r  <= 32'h0;
      for (int i = 0; i < 32; i++) cnt_r[i] <= 7'h0;
    end else begin
      flt_r    <= flt_nxt;
      rec_v_r  <= rec_v_nxt;
      rec_l_r  <= rec_l_nxt;
      rec_ch_r <= rec_ch_nxt;
      rec_t_r  <= rec_t_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

  // indicators and interrupt
  logic [9:0] blink_r, blink_nxt, link_r, link_nxt;
  logic       blink_ph_r, blink_ph_nxt, irq_src;
  assign irq_src = |(sts_r & mask_r);
  always_comb begin
    blink_nxt    = blink_r;
    blink_ph_nxt = blink_ph_r;
    if (tick) begin
      blink_nxt = (blink_r == 10'(`BLINK_MS - 1)) ? 10'h0 : blink_r + 10'h1;
      if (blink_r == 10'(`BLINK_MS - 1)) blink_ph_nxt = !blink_ph_r;
    end
    link_nxt = link_r;
    if (acc) link_nxt = 10'(`LINK_TIMEOUT_MS);
    else if (tick && link_r != 10'h0) link_nxt = link_r - 10'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_r    <= 10'h0;
      blink_ph_r <= 1'b0;
      link_r     <= 10'h0;
      irq        <= 1'b0;
      run_led    <= 1'b0;
      link_led   <= 1'b0;
      fault_led  <= 1'b0;
      level_led  <= 32'h0;
    end else begin
      blink_r    <= blink_nxt;
      blink_ph_r <= blink_ph_nxt;
      link_r     <= link_nxt;
      irq        <= irq_src;
      run_led    <= health_r == HEALTH_RUN && (!loaded_r || blink_ph_r);
      link_led   <= link_r != 10'h0;
      fault_led  <= health_r == HEALTH_FAULT;
      level_led  <= flt_r;
    end
  end

  // assertions
  property p_irq;
    @(posedge pclk) disable iff (!presetn) irq_src |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");
  property p_stamp;
    @(posedge pclk) disable iff (!presetn) commit |=> rec_t_r == $past(ms_r) && rec_v_r;
  endproperty
  a_stamp: assert property (p_stamp) else $error("record time wrong");
  property p_rec_ch;
    @(posedge pclk) disable iff (!presetn)
      commit |=> (rec_ch_r == $past(gnt) && level_led[rec_ch_r] == !rec_l_r)
                 ##1 (level_led[rec_ch_r] == rec_l_r);
  endproperty
  a_rec_ch: assert property (p_rec_ch) else $error("record channel wrong");
  property p_filt_bad;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && !pready && pwrite && in_filt && !filt_ok |=> pslverr && pready;
  endproperty
  a_filt_bad: assert property (p_filt_bad) else $error("bad filter not refused");
  property p_stable;
    @(posedge pclk) disable iff (!presetn)
      commit |-> cnt_r[gnt] >= filt_r[gnt] && filt_r[gnt] >= 7'(`FILT_MIN_MS);
  endproperty
  a_stable: assert property (p_stable) else $error("change accepted early");
  property p_run;
    @(posedge pclk) disable iff (!presetn)
      !loaded_r && health_r == HEALTH_RUN |=> run_led;
  endproperty
  a_run: assert property (p_run) else $error("run lamp not steady");
  property p_fault;
    @(posedge pclk) disable iff (!presetn)
      health_r == HEALTH_RUN && mismatch |=> !loaded_r && sts_r[`STS_FAULT] ##1 fault_led;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not handled");
  property p_link;
    @(posedge pclk) disable iff (!presetn) acc |=> ##1 link_led;
  endproperty
  a_link: assert property (p_link) else $error("link lamp dark");
  property p_level;
    @(posedge pclk) disable iff (!presetn) 1'b1 |=> level_led == $past(flt_r);
  endproperty
  a_level: assert property (p_level) else $error("channel lamps wrong");
endmodule

// ==== sim/ctrl_cpu_model.sv ====
// Purpose: controller side, APB master that loads and drains the recorder
// Assumes: one transfer at a time, called from the bench
// Notes:   random idle gaps give prompt and slow requests
`timescale 1ns/100ps
module ctrl_cpu_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic hung);
    int n;
    n = 0;
    repeat ($urandom % 3) @(posedge pclk);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd   = prdata;
    err  = pslverr;
    hung = (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // stale data would hide a slave sampling too late
    pwdata  <= ~d;
  endtask
endmodule

// ==== sim/input_event_timestamp_module_bench.sv ====
// Purpose: self-checking bench of the event recorder
// Assumes: short ms tick set by parameter
// Notes:   fault path needs injection, only its idle lamp is checked
`timescale 1ns/100ps
`include "event_consts.svh"
module input_event_timestamp_module_bench;
  import event_pkg::*;
  localparam int TICK = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        irq, run_led, link_led, fault_led;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, level_led, rd, din, lv, t0;
  int          errors, num_checks;

  input_event_timestamp_module #(.TICK_CYCLES(TICK)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .din_grp0(din[15:0]), .din_grp1(din[31:16]), .irq(irq), .run_led(run_led),
    .link_led(link_led), .fault_led(fault_led), .level_led(level_led));
  ctrl_cpu_model cpu (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  function automatic logic [31:0] exp_info(input int ch, input logic l);
    return (32'h1 << `REC_VALID) | ({31'h0, l} << `REC_LVL) | 32'(ch);
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic wr, input logic [11:0] a, input logic [31:0] d,
                    input logic eerr);
    logic err, hung;
    cpu.xfer(wr, a, d, rd, err, hung);
    check({31'h0, hung}, 32'h0);
    if (hung) complete_run();
    check({31'h0, err}, {31'h0, eerr});
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, s}, 32'h1);
    if (s !== 1'b1) complete_run();
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    int ch, f, n;
    logic v;
    presetn = 1'b0;
    din = 32'h0;
    lv = 32'h0;
    errors = 0;
    num_checks = 0;
    void'($urandom(68413));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    check({29'h0, run_led, link_led, fault_led}, 32'h4);
    check(level_led, 32'h0);
    rw(0, `ADDR_FILT_BASE + 12'h004, 0, 0);
    check(rd, {25'h0, `FILT_RESET});
    rw(1, `ADDR_FILT_BASE, 32'h9, 1);
    rw(0, `ADDR_FILT_BASE, 0, 0);
    check(rd, {25'h0, `FILT_RESET});
    rw(1, `ADDR_FILT_LAST, 32'h65, 1);
    rw(0, 12'h020, 0, 1);
    rw(1, `ADDR_FILT_LAST, 32'h64, 0);
    rw(0, `ADDR_FILT_LAST, 0, 0);
    check(rd, 32'h64);
    check({31'h0, link_led}, 32'h1);
    rw(1, `ADDR_CTRL, 32'h1, 0);
    for (int i = 0; i < 6; i++) begin
      ch = $urandom % 32;
      f = 10 + $urandom % 6;
      rw(1, `ADDR_FILT_BASE + 12'(4 * ch), f, 0);
      rw(1, `ADDR_MASK, i % 2, 0);
      din[ch] <= ~din[ch];
      repeat ((f - 2) * TICK) @(posedge pclk);
      din[ch] <= ~din[ch];
      repeat (3 * TICK) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      check(level_led, lv);
      rw(0, `ADDR_TIME, 0, 0);
      t0 = rd;
      din[ch] <= ~din[ch];
      lv[ch] = ~lv[ch];
      repeat ((f - 1) * TICK) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      if (i % 2) wait_hi(irq, 4 * TICK);
      else begin
        repeat (4 * TICK) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        rw(0, `ADDR_STATUS, 0, 0);
        check(rd, 32'h1);
        rw(1, `ADDR_MASK, 32'h1, 0);
        wait_hi(irq, 4);
      end
      rw(0, `ADDR_REC_INFO, 0, 0);
      check(rd, exp_info(ch, lv[ch]));
      rw(0, `ADDR_REC_TIME, 0, 0);
      check({31'h0, (rd - t0 >= f) && (rd - t0 <= f + 2)}, 32'h1);
      check(level_led, lv);
      rw(1, `ADDR_STATUS, 32'h1, 0);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      rw(0, `ADDR_REC_INFO, 0, 0);
      check({31'h0, rd[`REC_VALID]}, 32'h0);
    end
    v = run_led;
    n = 0;
    while (run_led === v && n < 10100) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, run_led}, {31'h0, ~v});
    rw(1, `ADDR_CTRL, 32'h0, 0);
    repeat (3) @(posedge pclk);
    n = 0;
    for (int k = 0; k < 10500; k++) begin
      @(posedge pclk);
      n += (run_led !== 1'b1);
    end
    check(32'(n), 32'h0);
    check({30'h0, link_led, fault_led}, 32'h0);
    complete_run();
  end
endmodule
